// ==== common/hps_pkg.sv ====
// constants and types shared by the host port selector
// Summary of operation
// - accept first reply for option commands 00,01,03,05,06,07,08,0b,0c,0f,14,15
// - reject for 02,04,09,0a,0d,0e; unknown 10-13,16-1f; reserved 20-ff, no second
// - second reply execute-ok for 01,09,14; check-condition for 08; none for 00,0f
// - main command 01 on selected parallel init, option command 01, or cold start
// - main command 04 sends name data after option command 05
// - main command 07 whenever the emulation type changes
// - emergency command raises main 15 then main 14 as its reply
// - state reply on streams status chars via card input register, framed by 0e
// - below slow threshold, intake continues at one byte per slow interval
// - buffer full keeps the selected parallel port busy without a break
// - manual mode accepts data only from the configured default port
// - automatic mode starts idle, then selects the first port that sends data
// - automatic mode returns to idle after a timed standby
// - selection holds while the host sends or the buffer stays full
// - parallel busy whenever another port is selected
// - serial terminal-ready at mark whenever another port is selected
// - at reset and idle: parallel ready, serial terminal-ready at space
// - init strobe of an unselected port is ignored
// - serial: x-off and dtr off below 1024 free, x-on and on above 2048
package hps_pkg;

  // ----------------------------------------
  // port selection states
  // ----------------------------------------
  typedef enum logic [1:0] {
    SEL_IDLE = 2'b00,
    SEL_PAR = 2'b01,
    SEL_SER = 2'b10,
    SEL_CARD = 2'b11
  } selState_t;

  // ----------------------------------------
  // option command replies
  // ----------------------------------------
  localparam logic [1:0] RA_ACCEPT = 2'h0;
  localparam logic [1:0] RA_REJECT = 2'h1;
  localparam logic [1:0] RA_UNKNOWN = 2'h2;
  localparam logic [1:0] RA_RESERVED = 2'h3;
  localparam logic [1:0] RB_EXEC_OK = 2'h1;
  localparam logic [1:0] RB_CHECK_COND = 2'h2;

  // ----------------------------------------
  // main command codes and pending slots
  // ----------------------------------------
  localparam logic [7:0] MC_RESET = 8'h01;
  localparam logic [7:0] MC_NAME = 8'h04;
  localparam logic [7:0] MC_EMUL = 8'h07;
  localparam logic [7:0] MC_STATUS = 8'h0e;
  localparam logic [7:0] MC_EMG_SEND = 8'h15;
  localparam logic [7:0] MC_EMG_REPLY = 8'h14;
  localparam logic [7:0] OC_RESET = 8'h01;
  localparam logic [7:0] OC_NAME = 8'h05;
  localparam int NUM_MC = 6;
  localparam int P_RESET = 0;
  localparam int P_NAME = 1;
  localparam int P_EMUL = 2;
  localparam int P_STATUS = 3;
  localparam int P_EMG_SEND = 4;
  localparam int P_EMG_REPLY = 5;

  // ----------------------------------------
  // serial flow control
  // ----------------------------------------
  localparam logic [7:0] XON_CODE = 8'h11;
  localparam logic [7:0] XOFF_CODE = 8'h13;
  localparam logic [15:0] DTR_OFF_BELOW = 16'h0400;
  localparam logic [15:0] DTR_ON_ABOVE = 16'h0800;

  // ----------------------------------------
  // buffering and timing
  // ----------------------------------------
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 16;
  localparam logic [15:0] SLOW_THRESH_DEF = 16'h0200;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned IDLE_TIME_S = 10;
  localparam int unsigned SLOW_TIME_S = 15;
  localparam int unsigned IDLE_CYCLES_DEF = IDLE_TIME_S * CLK_HZ;
  localparam int unsigned SLOW_CYCLES_DEF = SLOW_TIME_S * CLK_HZ;

endpackage

// ==== rtl/host_port_selector.sv ====
// host port selector with its intake fifo
`timescale 1ns/1ps

// ----------------------------------------
// intake fifo
// ----------------------------------------
module hps_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic inValid,
  input wire logic [W-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [W-1:0] outData,
  input wire logic outReady
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  assign inReady = count_q != (AW+1)'(D);
  assign outValid = count_q != '0;
  assign outData = mem[rdPtr_q];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == AW'(D - 1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == AW'(D - 1)) ? '0 : rdPtr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ----------------------------------------
// top
// ----------------------------------------
module host_port_selector #(
  parameter int unsigned IDLE_CYCLES = hps_pkg::IDLE_CYCLES_DEF,
  parameter int unsigned SLOW_CYCLES = hps_pkg::SLOW_CYCLES_DEF,
  parameter logic [15:0] SLOW_THRESH = hps_pkg::SLOW_THRESH_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // configuration
  input wire logic autoSelect,
  input wire hps_pkg::selState_t defaultPort,
  input wire logic [1:0] emulationType,
  input wire logic coldStart,
  // host ports
  input wire logic parValid,
  input wire logic [7:0] parData,
  input wire logic parInit,
  output logic parAck,
  output logic parBusy,
  input wire logic serValid,
  input wire logic [7:0] serData,
  output logic serAck,
  output logic serDtrMark,
  output logic serFlowValid,
  output logic [7:0] serFlowCode,
  input wire logic cardValid,
  input wire logic [7:0] cardData,
  output logic cardAck,
  // option card commands
  input wire logic optValid,
  input wire logic [7:0] optCmd,
  output logic replyAValid,
  output logic [1:0] replyACode,
  output logic replyBValid,
  output logic [1:0] replyBCode,
  input wire logic emgValid,
  input wire logic [7:0] emgCode,
  output logic mainCmdValid,
  output logic [7:0] mainCmd,
  output logic [7:0] mainCmdArg,
  // status reply stream
  input wire logic stateReplyOn,
  input wire logic stsValid,
  input wire logic [7:0] stsChar,
  output logic cardInValid,
  output logic [7:0] cardInputRegister,
  // print data and buffer space
  input wire logic [15:0] bufFree,
  output logic outValid,
  output logic [7:0] outData,
  input wire logic outReady,
  output hps_pkg::selState_t selected
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic [1:0] replyA(input logic [7:0] c);
    logic [1:0] r;
    r = hps_pkg::RA_RESERVED;
    if (c < 8'h20) begin
      case (c)
        8'h00, 8'h01, 8'h03, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0b, 8'h0c, 8'h0f, 8'h14, 8'h15: r = hps_pkg::RA_ACCEPT;
        8'h02, 8'h04, 8'h09, 8'h0a, 8'h0d, 8'h0e: r = hps_pkg::RA_REJECT;
        default: r = hps_pkg::RA_UNKNOWN;
      endcase
    end
    return r;
  endfunction

  function automatic logic [1:0] replyB(input logic [7:0] c);
    logic [1:0] r;
    r = 2'h0;
    case (c)
      8'h01, 8'h09, 8'h14: r = hps_pkg::RB_EXEC_OK;
      8'h08: r = hps_pkg::RB_CHECK_COND;
      default: r = 2'h0;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] slotCode(input logic [hps_pkg::NUM_MC-1:0] g);
    logic [7:0] r;
    r = hps_pkg::MC_EMG_REPLY;
    if (g[hps_pkg::P_RESET]) r = hps_pkg::MC_RESET;
    else if (g[hps_pkg::P_NAME]) r = hps_pkg::MC_NAME;
    else if (g[hps_pkg::P_EMUL]) r = hps_pkg::MC_EMUL;
    else if (g[hps_pkg::P_STATUS]) r = hps_pkg::MC_STATUS;
    else if (g[hps_pkg::P_EMG_SEND]) r = hps_pkg::MC_EMG_SEND;
    return r;
  endfunction

  // ----------------------------------------
  // intake and throttling
  // ----------------------------------------
  hps_pkg::selState_t selQ, selD;
  logic curValid;
  logic [7:0] curData;
  logic fifoReady;
  logic bufFull;
  logic slowZone;
  logic slowTick;
  logic take;
  logic [31:0] slowCnt_q;
  logic [31:0] idleCnt_q;

  always_comb begin
    curValid = 1'b0;
    curData = parData;
    case (selQ)
      hps_pkg::SEL_PAR: curValid = parValid;
      hps_pkg::SEL_SER: begin
        curValid = serValid;
        curData = serData;
      end
      hps_pkg::SEL_CARD: begin
        curValid = cardValid;
        curData = cardData;
      end
      default: curValid = 1'b0;
    endcase
  end

  assign bufFull = !fifoReady || bufFree == 16'h0000;
  assign slowZone = bufFree < SLOW_THRESH;
  assign slowTick = slowCnt_q >= SLOW_CYCLES - 1;
  assign take = curValid && !bufFull && (!slowZone || slowTick);

  hps_fifo #(.W(hps_pkg::FIFO_W), .D(hps_pkg::FIFO_D)) intake (
    .clk(clk),
    .rst_b(rst_b),
    .inValid(take),
    .inData(curData),
    .inReady(fifoReady),
    .outValid(outValid),
    .outData(outData),
    .outReady(outReady)
  );

  // one byte per slow interval keeps the host from timing out
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slowCnt_q <= 32'h0000_0000;
    end else if (take) begin
      slowCnt_q <= 32'h0000_0000;
    end else if (!slowTick) begin
      slowCnt_q <= slowCnt_q + 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // port selection
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      idleCnt_q <= 32'h0000_0000;
    end else if (selQ == hps_pkg::SEL_IDLE || curValid || bufFull) begin
      idleCnt_q <= 32'h0000_0000;
    end else if (idleCnt_q < IDLE_CYCLES - 1) begin
      idleCnt_q <= idleCnt_q + 32'h0000_0001;
    end
  end

  always_comb begin
    selD = selQ;
    if (!autoSelect) begin
      selD = defaultPort;
    end else begin
      case (selQ)
        hps_pkg::SEL_IDLE: begin
          if (parValid) selD = hps_pkg::SEL_PAR;
          else if (serValid) selD = hps_pkg::SEL_SER;
          else if (cardValid) selD = hps_pkg::SEL_CARD;
        end
        hps_pkg::SEL_PAR, hps_pkg::SEL_SER, hps_pkg::SEL_CARD: begin
          // a byte or a full buffer in the last quiet cycle still holds the port
          if (idleCnt_q >= IDLE_CYCLES - 1 && !curValid && !bufFull) selD = hps_pkg::SEL_IDLE;
        end
        default: selD = hps_pkg::SEL_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      selQ <= hps_pkg::SEL_IDLE;
    end else begin
      selQ <= selD;
    end
  end

  // ----------------------------------------
  // port handshake lines
  // ----------------------------------------
  logic dtrOn_q;
  logic dtrOnD;

  always_comb begin
    dtrOnD = dtrOn_q;
    if (selQ != hps_pkg::SEL_SER) dtrOnD = 1'b1;
    else if (bufFree < hps_pkg::DTR_OFF_BELOW) dtrOnD = 1'b0;
    else if (bufFree > hps_pkg::DTR_ON_ABOVE) dtrOnD = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dtrOn_q <= 1'b1;
      serFlowValid <= 1'b0;
      serFlowCode <= hps_pkg::XON_CODE;
    end else begin
      dtrOn_q <= dtrOnD;
      serFlowValid <= selQ == hps_pkg::SEL_SER && dtrOnD != dtrOn_q;
      serFlowCode <= dtrOnD ? hps_pkg::XON_CODE : hps_pkg::XOFF_CODE;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      parBusy <= 1'b0;
      serDtrMark <= 1'b0;
      selected <= hps_pkg::SEL_IDLE;
    end else begin
      selected <= selQ;
      case (selQ)
        hps_pkg::SEL_IDLE: begin
          parBusy <= 1'b0;
          serDtrMark <= 1'b0;
        end
        hps_pkg::SEL_PAR: begin
          parBusy <= bufFull || (slowZone && !slowTick);
          serDtrMark <= 1'b1;
        end
        hps_pkg::SEL_SER: begin
          parBusy <= 1'b1;
          serDtrMark <= !dtrOn_q;
        end
        default: begin
          parBusy <= 1'b1;
          serDtrMark <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      parAck <= 1'b0;
      serAck <= 1'b0;
      cardAck <= 1'b0;
    end else begin
      parAck <= take && selQ == hps_pkg::SEL_PAR;
      serAck <= take && selQ == hps_pkg::SEL_SER;
      cardAck <= take && selQ == hps_pkg::SEL_CARD;
    end
  end

  // ----------------------------------------
  // option command replies
  // ----------------------------------------
  logic bPend_q;
  logic [1:0] bCode_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      replyAValid <= 1'b0;
      replyACode <= hps_pkg::RA_ACCEPT;
      bPend_q <= 1'b0;
      bCode_q <= 2'h0;
      replyBValid <= 1'b0;
      replyBCode <= 2'h0;
    end else begin
      replyAValid <= optValid;
      replyACode <= replyA(optCmd);
      bPend_q <= optValid && replyB(optCmd) != 2'h0;
      bCode_q <= replyB(optCmd);
      replyBValid <= bPend_q;
      replyBCode <= bCode_q;
    end
  end

  // ----------------------------------------
  // main commands toward the card
  // ----------------------------------------
  // events of one cycle queue up; one command leaves per cycle
  logic [hps_pkg::NUM_MC-1:0] pend_q;
  logic [hps_pkg::NUM_MC-1:0] ev;
  logic [hps_pkg::NUM_MC-1:0] grant;
  logic [1:0] emul_q;
  logic stRep_q;
  logic [7:0] emgArg_q;
  // stored copies are primed on the first edge, so a reset makes no false change
  logic armed_q;

  always_comb begin
    ev = '0;
    ev[hps_pkg::P_RESET] = (parInit && selQ == hps_pkg::SEL_PAR) || coldStart
      || (optValid && optCmd == hps_pkg::OC_RESET);
    ev[hps_pkg::P_NAME] = optValid && optCmd == hps_pkg::OC_NAME;
    ev[hps_pkg::P_EMUL] = armed_q && emulationType != emul_q;
    ev[hps_pkg::P_STATUS] = armed_q && stateReplyOn != stRep_q;
    ev[hps_pkg::P_EMG_SEND] = emgValid;
    ev[hps_pkg::P_EMG_REPLY] = emgValid;
  end

  assign grant = pend_q & (~pend_q + 1'b1);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_q <= '0;
      emul_q <= 2'h0;
      stRep_q <= 1'b0;
      emgArg_q <= 8'h00;
      armed_q <= 1'b0;
    end else begin
      armed_q <= 1'b1;
      pend_q <= (pend_q & ~grant) | ev;
      emul_q <= emulationType;
      stRep_q <= stateReplyOn;
      if (emgValid) emgArg_q <= emgCode;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mainCmdValid <= 1'b0;
      mainCmd <= 8'h00;
      mainCmdArg <= 8'h00;
    end else begin
      mainCmdValid <= pend_q != '0;
      mainCmd <= slotCode(grant);
      mainCmdArg <= emgArg_q;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cardInValid <= 1'b0;
      cardInputRegister <= 8'h00;
    end else begin
      cardInValid <= stRep_q && stsValid;
      cardInputRegister <= stsChar;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic otherEv;
  assign otherEv = coldStart || optValid || emgValid || ev[hps_pkg::P_EMUL] || ev[hps_pkg::P_STATUS];

  sequence emgOut;
    mainCmdValid && mainCmd == hps_pkg::MC_EMG_SEND ##1 mainCmdValid && mainCmd == hps_pkg::MC_EMG_REPLY;
  endsequence

  a_reply_accept_07: assert property (optValid && optCmd == 8'h07 |=> replyAValid && replyACode == 2'h0)
    else $error("accept reply missing");
  a_reply_reserved_b: assert property (optValid && optCmd >= 8'h20 |=> replyACode == 2'h3 ##1 !replyBValid)
    else $error("reserved reply wrong");
  a_reply_b_exec: assert property (optValid && optCmd == 8'h01 |=> ##1 replyBValid && replyBCode == 2'h1)
    else $error("execute ok missing");
  a_emg_order: assert property (emgValid && pend_q == '0 |=> ##1 emgOut)
    else $error("emergency commands out of order");
  a_init_ignored: assert property (parInit && selQ != hps_pkg::SEL_PAR && !otherEv && pend_q == '0 |=> ##1 !mainCmdValid)
    else $error("init of unselected port acted on");
  a_full_busy: assert property (selQ == hps_pkg::SEL_PAR && bufFree == 16'h0000 |=> parBusy)
    else $error("full buffer not busy");
  a_par_busy_other: assert property (selQ inside {hps_pkg::SEL_SER, hps_pkg::SEL_CARD} |=> parBusy)
    else $error("parallel not busy while unselected");
  a_dtr_mark_other: assert property (selQ inside {hps_pkg::SEL_PAR, hps_pkg::SEL_CARD} |=> serDtrMark)
    else $error("dtr not mark while unselected");
  a_idle_ready: assert property (selQ == hps_pkg::SEL_IDLE |=> !parBusy && !serDtrMark)
    else $error("idle lines wrong");
  a_idle_hold: assert property (autoSelect && selQ != hps_pkg::SEL_IDLE && curValid |=> selQ == $past(selQ))
    else $error("selection dropped while sending");
endmodule

// ==== tb/host_port_model.sv ====
// host computer model for one host port
`timescale 1ns/1ps
module host_port_model (
  // clock
  input wire logic clk,
  // host port
  input wire logic ack,
  output logic valid,
  output logic [7:0] data
);
  initial begin
    valid = 1'b0;
    data = 8'h00;
  end
  // hold the byte until ack; give up after limit cycles
  task automatic send(input logic [7:0] b, input int limit, output logic gone);
    int n;
    @(negedge clk);
    valid = 1'b1;
    data = b;
    n = 0;
    gone = 1'b0;
    while (!gone && n < limit) begin
      @(negedge clk);
      gone = (ack === 1'b1);
      n++;
    end
    valid = 1'b0;
    // released lines must not keep showing the byte
    data = ~b;
  endtask
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the host port selector
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int IDLE_N = 50;
  localparam int SLOW_N = 20;
  logic clk, rst_b, autoSelect, coldStart, parInit, optValid, emgValid, stateReplyOn, stsValid, outReady, drainOn;
  hps_pkg::selState_t defaultPort, selected;
  logic [1:0] emulationType, replyACode, replyBCode;
  logic [7:0] optCmd, emgCode, stsChar, parData, serData, cardData, mainCmd, mainCmdArg, cardInputRegister;
  logic [7:0] outData, serFlowCode, lastEmg;
  logic [15:0] bufFree;
  logic parValid, serValid, cardValid, parAck, serAck, cardAck, parBusy, serDtrMark, serFlowValid, gone;
  logic replyAValid, replyBValid, mainCmdValid, cardInValid, outValid;
  logic [7:0] qA[$], qB[$], qM[$], qD[$], qF[$], qS[$];
  int errTotal, nTests;
  int seed = 68;

  host_port_selector #(.IDLE_CYCLES(IDLE_N), .SLOW_CYCLES(SLOW_N)) dut_u (
    .clk(clk), .rst_b(rst_b), .autoSelect(autoSelect), .defaultPort(defaultPort),
    .emulationType(emulationType), .coldStart(coldStart), .parValid(parValid), .parData(parData),
    .parInit(parInit), .parAck(parAck), .parBusy(parBusy), .serValid(serValid), .serData(serData),
    .serAck(serAck), .serDtrMark(serDtrMark), .serFlowValid(serFlowValid), .serFlowCode(serFlowCode),
    .cardValid(cardValid), .cardData(cardData), .cardAck(cardAck), .optValid(optValid), .optCmd(optCmd),
    .replyAValid(replyAValid), .replyACode(replyACode), .replyBValid(replyBValid), .replyBCode(replyBCode),
    .emgValid(emgValid), .emgCode(emgCode), .mainCmdValid(mainCmdValid), .mainCmd(mainCmd),
    .mainCmdArg(mainCmdArg), .stateReplyOn(stateReplyOn), .stsValid(stsValid), .stsChar(stsChar),
    .cardInValid(cardInValid), .cardInputRegister(cardInputRegister), .bufFree(bufFree),
    .outValid(outValid), .outData(outData), .outReady(outReady), .selected(selected));
  host_port_model uPar (.clk(clk), .ack(parAck), .valid(parValid), .data(parData));
  host_port_model uSer (.clk(clk), .ack(serAck), .valid(serValid), .data(serData));
  host_port_model uCard (.clk(clk), .ack(cardAck), .valid(cardValid), .data(cardData));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    nTests++;
    if (seen !== exp) begin
      errTotal++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic do_reset(input logic mode);
    @(negedge clk);
    rst_b = 1'b0;
    autoSelect = mode;
    tick(20);
    rst_b = 1'b1;
    tick(3);
  endtask
  // note the byte first: it may leave the fifo before the ack is seen
  task automatic put(input int p, input logic [7:0] v, input int limit, input logic exp);
    if (exp) qD.push_back(v);
    case (p)
      0: uPar.send(v, limit, gone);
      1: uSer.send(v, limit, gone);
      default: uCard.send(v, limit, gone);
    endcase
    chk({7'h0, gone}, {7'h0, exp});
  endtask
  task automatic opt(input logic [7:0] c);
    logic [1:0] a;
    if (c >= 8'h20) a = hps_pkg::RA_RESERVED;
    else if (c inside {[8'h10:8'h13], [8'h16:8'h1f]}) a = hps_pkg::RA_UNKNOWN;
    else if (c inside {8'h02, 8'h04, 8'h09, 8'h0a, 8'h0d, 8'h0e}) a = hps_pkg::RA_REJECT;
    else a = hps_pkg::RA_ACCEPT;
    qA.push_back({6'h0, a});
    if (c inside {8'h01, 8'h09, 8'h14}) qB.push_back({6'h0, hps_pkg::RB_EXEC_OK});
    if (c == 8'h08) qB.push_back({6'h0, hps_pkg::RB_CHECK_COND});
    if (c == hps_pkg::OC_RESET) qM.push_back(hps_pkg::MC_RESET);
    if (c == hps_pkg::OC_NAME) qM.push_back(hps_pkg::MC_NAME);
    @(negedge clk);
    optValid = 1'b1;
    optCmd = c;
    @(negedge clk);
    optValid = 1'b0;
    optCmd = ~c;
    tick(3);
  endtask

  // ----------------------------------------
  // clock, drain and result monitor
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(negedge clk) outReady <= drainOn & 1'($random(seed));
  always @(posedge clk) begin
    if (replyAValid === 1'b1) chk({6'h0, replyACode}, qA.size() > 0 ? qA.pop_front() : 8'hxx);
    if (replyBValid === 1'b1) chk({6'h0, replyBCode}, qB.size() > 0 ? qB.pop_front() : 8'hxx);
    if (mainCmdValid === 1'b1) begin
      if (mainCmd === hps_pkg::MC_EMG_REPLY) chk(mainCmdArg, lastEmg);
      chk(mainCmd, qM.size() > 0 ? qM.pop_front() : 8'hxx);
    end
    if (serFlowValid === 1'b1) chk(serFlowCode, qF.size() > 0 ? qF.pop_front() : 8'hxx);
    if (cardInValid === 1'b1) chk(cardInputRegister, qS.size() > 0 ? qS.pop_front() : 8'hxx);
    if (outValid === 1'b1 && outReady === 1'b1) chk(outData, qD.size() > 0 ? qD.pop_front() : 8'hxx);
  end
  // a hang is cut short well past the expected run of some 1700 cycles
  initial begin
    repeat (20000) @(posedge clk);
    errTotal++;
    report_and_stop();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rst_b, autoSelect, coldStart, parInit, optValid, emgValid, stateReplyOn, stsValid, drainOn} = '0;
    defaultPort = hps_pkg::SEL_PAR;
    {emulationType, optCmd, emgCode, stsChar, lastEmg} = '0;
    bufFree = 16'h0bb8;
    errTotal = 0;
    nTests = 0;
    do_reset(1'b0);
    chk(selected, hps_pkg::SEL_PAR);
    chk(serDtrMark, 1'b1);
    put(2, 8'h5a, 10, 1'b0);
    put(1, 8'h3c, 10, 1'b0);
    // fill the fifo with the drain stalled, then drain it
    for (int i = 0; i < hps_pkg::FIFO_D; i++) put(0, 8'($random(seed)), 10, 1'b1);
    put(0, 8'hee, 10, 1'b0);
    chk(parBusy, 1'b1);
    drainOn = 1'b1;
    tick(60);
    chk(8'(qD.size()), 8'h00);
    bufFree = 16'h0000;
    put(0, 8'h55, 10, 1'b0);
    chk(parBusy, 1'b1);
    bufFree = 16'h0bb8;
    qM.push_back(hps_pkg::MC_RESET);
    parInit = 1'b1;
    tick(1);
    parInit = 1'b0;
    tick(4);
    qM.push_back(hps_pkg::MC_RESET);
    coldStart = 1'b1;
    tick(1);
    coldStart = 1'b0;
    tick(4);
    qM.push_back(hps_pkg::MC_EMUL);
    emulationType = 2'h2;
    tick(5);
    for (int e = 0; e < 2; e++) begin
      qM.push_back(hps_pkg::MC_EMG_SEND);
      qM.push_back(hps_pkg::MC_EMG_REPLY);
      lastEmg = 8'(e);
      emgCode = 8'(e);
      emgValid = 1'b1;
      tick(1);
      emgValid = 1'b0;
      emgCode = 8'hff;
      tick(5);
    end
    // status chars pass only while state reply is on
    qM.push_back(hps_pkg::MC_STATUS);
    stateReplyOn = 1'b1;
    tick(3);
    for (int s = 0; s < 3; s++) begin
      stsChar = 8'($random(seed));
      if (s < 2) qS.push_back(stsChar);
      if (s == 2) qM.push_back(hps_pkg::MC_STATUS);
      if (s == 2) stateReplyOn = 1'b0;
      tick(2);
      stsValid = 1'b1;
      tick(1);
      stsValid = 1'b0;
    end
    tick(4);
    for (int c = 0; c < 256; c++) opt(8'(c));
    // automatic selection on the serial port
    do_reset(1'b1);
    chk(selected, hps_pkg::SEL_IDLE);
    chk({parBusy, serDtrMark}, 8'h00);
    parInit = 1'b1;
    tick(1);
    parInit = 1'b0;
    tick(4);
    bufFree = 16'h05dc;
    for (int i = 0; i < 3; i++) put(1, 8'($random(seed)), 10, 1'b1);
    tick(2);
    chk(selected, hps_pkg::SEL_SER);
    chk(parBusy, 1'b1);
    put(0, 8'h99, 10, 1'b0);
    qF.push_back(hps_pkg::XOFF_CODE);
    bufFree = 16'h01f4;
    tick(4);
    chk(serDtrMark, 1'b1);
    bufFree = 16'h0000;
    put(1, 8'h77, 3 * SLOW_N, 1'b0);
    bufFree = 16'h0064;
    put(1, 8'($random(seed)), 3 * SLOW_N, 1'b1);
    // right after a slow take the next byte must wait a whole interval
    put(1, 8'h66, SLOW_N / 2, 1'b0);
    put(1, 8'($random(seed)), 3 * SLOW_N, 1'b1);
    qF.push_back(hps_pkg::XON_CODE);
    bufFree = 16'h0bb8;
    tick(4);
    chk(serDtrMark, 1'b0);
    tick(IDLE_N - 20);
    chk(selected, hps_pkg::SEL_SER);
    tick(40);
    chk(selected, hps_pkg::SEL_IDLE);
    chk({parBusy, serDtrMark}, 8'h00);
    put(2, 8'($random(seed)), 10, 1'b1);
    tick(2);
    chk(selected, hps_pkg::SEL_CARD);
    chk({parBusy, serDtrMark}, 8'h03);
    tick(10);
    chk(8'(qA.size() + qB.size() + qM.size() + qD.size() + qF.size() + qS.size()), 8'h00);
    report_and_stop();
  end
endmodule
